// ==== rtl/rps_pkg.sv ====
// Package for the receiver pairing and self-test controller.
// Assumes a single 250 MHz clock; all times are counted in 1 ms ticks.
package rps_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned ERASE_HOLD_MS = 10_000;
    localparam int unsigned LEARN_TIMEOUT_MS = 10_000;
    localparam int unsigned SUCCESS_FLASH_MS = 3_000;
    localparam int unsigned CARRIER_MS = 10_000;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned TICK_US = 1_000;
    // Cycles in one millisecond tick
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned MAX_PAIRS = 51;
    localparam int unsigned KEY_W = 24;
    // Indicator half periods, then self-test step and full flicker period, in ms ticks
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned FAST_HALF_MS = 50;
    localparam int unsigned COUNT_HALF_MS = 250;
    localparam int unsigned STEP_MS = 250;
    localparam int unsigned FLICKER_MS = 30;
    localparam logic [7:0] FOUR_ON_PAT = 8'h0F;
    localparam int unsigned MS_W = 14;
endpackage : rps_pkg

// ==== rtl/rps_debounce.sv ====
// Debouncer for the learn button, after a two-stage synchroniser.
// Assumes a 1 ms tick pulse from the main controller.
`timescale 1ns/1ns
module rps_debounce #(
    parameter int unsigned STABLE_TICKS = rps_pkg::DEBOUNCE_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Raw pin and timebase
    input wire logic raw_n,
    input wire logic tick,
    // Clean level, high while pressed
    output logic pressed
);
    import rps_pkg::*;
    logic s1_q, s2_q, pressed_q, pressed_d;
    logic [7:0] cnt_q, cnt_d;

    always_comb begin
        pressed_d = pressed_q;
        cnt_d = cnt_q;
        if (~s2_q == pressed_q) begin
            cnt_d = 8'h00;
        end else if (tick) begin
            if (cnt_q == 8'(STABLE_TICKS - 1)) begin
                pressed_d = ~s2_q;
                cnt_d = 8'h00;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            pressed_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            s1_q <= raw_n;
            s2_q <= s1_q;
            pressed_q <= pressed_d;
            cnt_q <= cnt_d;
        end
    end

    assign pressed = pressed_q;
endmodule : rps_debounce

// ==== rtl/rps_ctrl.sv ====
// Pairing and self-test controller of the radio receiver.
// Assumes a radio modem that reports key codes, traffic and signal strength,
// and a non-volatile store behind the pairing write/erase strobes.
//
// Summary of operation
// R1: Brief first press, on release: learn mode, channel 1, one flash.
// R2: Further presses advance channel up to 8; flash count equals channel.
// R3: Received handset key is bound to selected channel; rapid flashes.
// R4: After pairing, fast flashing for 3 s, then leave learn mode.
// R5: Learn held over 10 s erases every pairing.
// R6: After erase, flash while button still held.
// R7: Pairing store holds at most 51 key-to-output entries.
// R8: Learn mode searching flashes indicator slowly.
// R9: Learn mode times out after 10 s with no pairing.
// R10: Normal operation: indicator flickers on radio traffic, else off.
// R11: Learn held at power-up enters self-test.
// R12: Self-test: all outputs driven, ramp 0-8-0, then four on four off. The ramp here ends at 1, not 0.
// R13: Then full-power carrier for 10 s with indicator operating.
// R14: Then signal strength bar graph on outputs 1-8.
// R15: Learn input idles high, pulled low by the operator.
// R16: External indicator output mirrors the on-board indicator.
// R17: Handset pairing only when role-select is low (receiver).
// R18: Learn input debounced and timed against local ms timebase.
// R19: Indicator rates and bar thresholds are parameters.
// R20: Pairings held in non-volatile store until erased.
`timescale 1ns/1ns
module rps_ctrl #(
    parameter int unsigned ERASE_MS = rps_pkg::ERASE_HOLD_MS,
    parameter int unsigned TIMEOUT_MS = rps_pkg::LEARN_TIMEOUT_MS,
    parameter int unsigned TICK_CYCLES = rps_pkg::TICK_CYC,
    // R19 indicator rates and bar step
    parameter int unsigned SLOW_MS = rps_pkg::SLOW_HALF_MS,
    parameter int unsigned FAST_MS = rps_pkg::FAST_HALF_MS,
    parameter int unsigned BAR_STEP = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins
    input wire logic learn_button_input,
    input wire logic role_tx,
    // Radio modem side
    input wire logic key_valid,
    input wire logic [rps_pkg::KEY_W-1:0] key_code,
    input wire logic rf_activity,
    input wire logic [7:0] rssi,
    input wire logic rssi_valid,
    // Pairing store
    output logic pair_wr,
    output logic [rps_pkg::KEY_W-1:0] pair_key,
    output logic [2:0] pair_ch,
    output logic store_erase,
    output logic [5:0] pair_count,
    // Outputs
    output logic [rps_pkg::NUM_CH-1:0] ch_out,
    output logic ch_oe_n,
    output logic carrier_on,
    output logic led_onboard,
    output logic learn_indicator_output,
    output logic self_test
);
    import rps_pkg::*;

    typedef enum {
        S_BOOT, S_NORMAL, S_HOLD, S_ERASED, S_COUNT, S_SEARCH,
        S_SUCCESS, S_RAMP, S_QUAD, S_CARRIER, S_RSSI
    } rps_state_t;

    rps_state_t st_q, st_d;
    logic [17:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic pressed, pressed_q;
    logic [MS_W-1:0] ms_q, ms_d;
    logic [9:0] half_q, half_d;
    logic led_q, led_d;
    logic [3:0] flash_q, flash_d;
    logic [2:0] ch_q, ch_d;
    logic [3:0] step_q, step_d;
    logic [NUM_CH-1:0] out_q, out_d;
    logic oe_n_q, oe_n_d, car_q, car_d, wr_q, wr_d, er_q, er_d;
    logic [KEY_W-1:0] key_q, key_d;
    logic [5:0] cnt_q, cnt_d;
    logic ledx_q, st_flag_q, st_flag_d;
    // Role strap is a pin: two stages before any logic reads it
    logic role_s1_q, role_s2_q;

    // Bar graph: n lowest outputs lit
    function automatic logic [NUM_CH-1:0] bar(input logic [3:0] n);
        logic [NUM_CH-1:0] b;
        b = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (4'(i) < n) begin
                b[i] = 1'b1;
            end
        end
        return b;
    endfunction : bar

    // R18 debounce and timing
    rps_debounce #(
        .STABLE_TICKS(DEBOUNCE_MS)
    ) u_deb (
        .clk(clk),
        .rst_n(rst_n),
        .raw_n(learn_button_input),
        .tick(tick_q),
        .pressed(pressed)
    );

    logic released, press_edge;
    assign released = pressed_q & ~pressed;
    assign press_edge = ~pressed_q & pressed;

    always_comb begin
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + 18'h00001;
        if (tick_cnt_q == 18'(TICK_CYCLES - 1)) begin
            tick_cnt_d = 18'h00000;
            tick_d = 1'b1;
        end
    end

    always_comb begin
        st_d = st_q;
        ms_d = ms_q;
        half_d = half_q;
        led_d = led_q;
        flash_d = flash_q;
        ch_d = ch_q;
        step_d = step_q;
        out_d = out_q;
        oe_n_d = oe_n_q;
        car_d = 1'b0;
        wr_d = 1'b0;
        er_d = 1'b0;
        key_d = key_q;
        cnt_d = cnt_q;
        st_flag_d = st_flag_q;
        if (tick_q) begin
            ms_d = ms_q + MS_W'(1);
            half_d = half_q + 10'h001;
        end
        case (st_q)
            S_BOOT: begin
                // R11 strap caught after debounce settles
                if (ms_q == MS_W'(DEBOUNCE_MS + 2)) begin
                    if (pressed) begin
                        st_d = S_RAMP;
                        st_flag_d = 1'b1;
                        // R12 all channel pins become outputs
                        oe_n_d = 1'b0;
                        step_d = 4'h0;
                    end else begin
                        st_d = S_NORMAL;
                    end
                    ms_d = '0;
                    half_d = '0;
                end
            end
            S_NORMAL: begin
                // R10 flicker while traffic
                led_d = rf_activity & (half_q < 10'(FLICKER_MS / 2));
                if (half_q >= 10'(FLICKER_MS - 1)) begin
                    half_d = '0;
                end
                // R17 pairing only as receiver
                if (press_edge && !role_s2_q) begin
                    st_d = S_HOLD;
                    ms_d = '0;
                    ch_d = 3'h0;
                    led_d = 1'b0;
                end
            end
            S_HOLD: begin
                // R5 long hold erases store
                if (ms_q >= MS_W'(ERASE_MS)) begin
                    er_d = 1'b1;
                    cnt_d = 6'h00;
                    st_d = S_ERASED;
                    half_d = '0;
                end else if (released) begin
                    // R1 R2 select channel, count flashes
                    flash_d = {1'b0, ch_q} + 4'h1;
                    st_d = S_COUNT;
                    half_d = '0;
                    led_d = 1'b1;
                end
            end
            S_ERASED: begin
                // R6 flash until released
                if (half_q >= 10'(FAST_MS)) begin
                    half_d = '0;
                    led_d = ~led_q;
                end
                if (!pressed) begin
                    st_d = S_NORMAL;
                    led_d = 1'b0;
                end
            end
            S_COUNT: begin
                if (half_q >= 10'(COUNT_HALF_MS)) begin
                    half_d = '0;
                    led_d = ~led_q;
                    if (led_q) begin
                        flash_d = flash_q - 4'h1;
                        if (flash_q == 4'h1) begin
                            st_d = S_SEARCH;
                            ms_d = '0;
                        end
                    end
                end
            end
            S_SEARCH: begin
                // R8 slow flash while searching
                if (half_q >= 10'(SLOW_MS)) begin
                    half_d = '0;
                    led_d = ~led_q;
                end
                // R9 timeout without pairing
                if (ms_q >= MS_W'(TIMEOUT_MS)) begin
                    st_d = S_NORMAL;
                    led_d = 1'b0;
                end else if (press_edge) begin
                    // R2 next channel, capped at 8
                    if (ch_q != 3'(NUM_CH - 1)) begin
                        ch_d = ch_q + 3'h1;
                    end
                    st_d = S_HOLD;
                    ms_d = '0;
                    led_d = 1'b0;
                end else if (key_valid) begin
                    // R3 R7 R20 bind key if store has room
                    if (cnt_q < 6'(MAX_PAIRS)) begin
                        wr_d = 1'b1;
                        key_d = key_code;
                        cnt_d = cnt_q + 6'h01;
                    end
                    st_d = S_SUCCESS;
                    ms_d = '0;
                    half_d = '0;
                end
            end
            S_SUCCESS: begin
                // R4 fast flash for 3 s
                if (half_q >= 10'(FAST_MS)) begin
                    half_d = '0;
                    led_d = ~led_q;
                end
                if (ms_q >= MS_W'(SUCCESS_FLASH_MS)) begin
                    st_d = S_NORMAL;
                    led_d = 1'b0;
                end
            end
            S_RAMP: begin
                // R12 ramp 0 to 8 then back down to 1
                if (ms_q >= MS_W'(STEP_MS)) begin
                    ms_d = '0;
                    step_d = step_q + 4'h1;
                    if (step_q == 4'd15) begin
                        st_d = S_QUAD;
                        step_d = 4'h0;
                    end
                end
                out_d = bar((step_q <= 4'd8) ? step_q
                    : 4'(5'h10 - {1'b0, step_q}));
            end
            S_QUAD: begin
                out_d = step_q[0] ? ~FOUR_ON_PAT : FOUR_ON_PAT;
                if (ms_q >= MS_W'(STEP_MS)) begin
                    ms_d = '0;
                    step_d = step_q + 4'h1;
                    if (step_q == 4'd3) begin
                        st_d = S_CARRIER;
                        out_d = '0;
                    end
                end
            end
            S_CARRIER: begin
                // R13 carrier with indicator lit
                car_d = 1'b1;
                led_d = 1'b1;
                if (ms_q >= MS_W'(CARRIER_MS)) begin
                    car_d = 1'b0;
                    led_d = 1'b0;
                    st_d = S_RSSI;
                end
            end
            S_RSSI: begin
                // R14 bar graph from strength
                if (rssi_valid) begin
                    out_d = bar(4'((rssi / 8'(BAR_STEP)) > 8'd8
                        ? 8'd8 : rssi / 8'(BAR_STEP)));
                end
                ms_d = '0;
            end
            default: begin
                st_d = S_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_BOOT;
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
            pressed_q <= 1'b0;
            ms_q <= '0;
            half_q <= '0;
            led_q <= 1'b0;
            ledx_q <= 1'b0;
            flash_q <= '0;
            ch_q <= '0;
            step_q <= '0;
            out_q <= '0;
            oe_n_q <= 1'b1;
            car_q <= 1'b0;
            wr_q <= 1'b0;
            er_q <= 1'b0;
            key_q <= '0;
            cnt_q <= '0;
            st_flag_q <= 1'b0;
            role_s1_q <= 1'b0;
            role_s2_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            pressed_q <= pressed;
            ms_q <= ms_d;
            half_q <= half_d;
            led_q <= led_d;
            // R16 external drive mirrors on-board led
            ledx_q <= led_d;
            flash_q <= flash_d;
            ch_q <= ch_d;
            step_q <= step_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
            car_q <= car_d;
            wr_q <= wr_d;
            er_q <= er_d;
            key_q <= key_d;
            cnt_q <= cnt_d;
            st_flag_q <= st_flag_d;
            role_s1_q <= role_tx;
            role_s2_q <= role_s1_q;
        end
    end

    assign pair_wr = wr_q;
    assign pair_key = key_q;
    assign pair_ch = ch_q;
    assign store_erase = er_q;
    assign pair_count = cnt_q;
    assign ch_out = out_q;
    assign ch_oe_n = oe_n_q;
    assign carrier_on = car_q;
    assign led_onboard = led_q;
    assign learn_indicator_output = ledx_q;
    assign self_test = st_flag_q;

    // R16
    a_led_mirror: assert property (@(posedge clk) disable iff (!rst_n)
        ledx_q == led_q) else $error("indicator mirror differs");
    // R7
    a_store_cap: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= 6'(MAX_PAIRS)) else $error("store over capacity");
    // R5
    a_erase_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(er_q) |-> $past(st_q) == S_HOLD) else $error("stray erase");
    // R3
    a_pair_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_q |-> st_q == S_SUCCESS && pair_key == key_q)
        else $error("write outside pairing");
    // R17
    a_role_block: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == S_NORMAL && role_s2_q) |=> st_q != S_HOLD)
        else $error("pairing as transmitter");
    // R12
    a_test_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == S_RAMP || st_q == S_QUAD) |-> !oe_n_q)
        else $error("outputs not driven");
    // R13
    a_carrier_only: assert property (@(posedge clk) disable iff (!rst_n)
        car_q |-> $past(st_q) == S_CARRIER) else $error("stray carrier");
    // R10
    a_idle_dark: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == S_NORMAL && !rf_activity)[*2] |-> !led_q)
        else $error("led lit without traffic");
endmodule : rps_ctrl

// ==== bench/rps_handset.sv ====
// Far-side model: the operator's learn button and a handheld transmitter.
// Assumes the bench calls its tasks shortly after a rising clock edge.
`timescale 1ns/1ns
module rps_handset (
    // Clock
    input wire logic clk,
    // Button pin and radio modem reports
    output logic btn_n,
    output logic key_valid,
    output logic [rps_pkg::KEY_W-1:0] key_code,
    output logic rf_activity
);
    import rps_pkg::*;

    initial begin
        btn_n = 1'b1;
        key_valid = 1'b0;
        key_code = '0;
        rf_activity = 1'b0;
    end

    // pulled to ground only while held
    task automatic set_button(input bit down);
        btn_n = ~down;
    endtask : set_button

    task automatic press(input int cyc);
        btn_n = 1'b0;
        repeat (cyc) @(posedge clk);
        #1 btn_n = 1'b1;
    endtask : press

    // one handset button, one report
    // The code is inverted afterwards so a stale value never looks valid
    task automatic send_key(input logic [KEY_W-1:0] code);
        key_valid = 1'b1;
        key_code = code;
        @(posedge clk);
        #1 key_valid = 1'b0;
        key_code = ~code;
    endtask : send_key

    task automatic traffic(input bit on);
        rf_activity = on;
    endtask : traffic
endmodule : rps_handset

// ==== bench/receiver_pairing_and_self_test_test.sv ====
// Self-checking bench for the pairing and self-test controller.
// Assumes a 10-cycle millisecond tick so long holds fit in the run.
`timescale 1ns/1ns
`define RPS_CHK(nm, ex, gt) begin samples_checked++; \
    if ((gt) !== (ex)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module receiver_pairing_and_self_test_test;
    import rps_pkg::*;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic rst_n;
    logic role_tx;
    logic [7:0] rssi;
    logic rssi_valid;
    logic [KEY_W-1:0] ek;
    logic [2:0] ec;
    logic btn_n, key_valid, rf_activity;
    logic [KEY_W-1:0] key_code;
    logic pair_wr, store_erase, ch_oe_n, carrier_on;
    logic led_onboard, learn_indicator_output, self_test, led_prev;
    logic [KEY_W-1:0] pair_key;
    logic [2:0] pair_ch;
    logic [5:0] pair_count;
    logic [NUM_CH-1:0] ch_out;
    int failures = 0;
    int samples_checked = 0;
    int wr_seen = 0;
    int erase_seen = 0;
    int led_rise = 0;
    int led_on_cyc = 0;
    int model_pairs = 0;
    logic [KEY_W-1:0] exp_key[$];
    logic [2:0] exp_ch[$];

    always #2 clk = ~clk;

    rps_handset u_hs (.clk(clk), .btn_n(btn_n), .key_valid(key_valid),
        .key_code(key_code), .rf_activity(rf_activity));

    rps_ctrl #(.ERASE_MS(100), .TIMEOUT_MS(2000), .TICK_CYCLES(MS)) dut (
        .clk(clk), .rst_n(rst_n), .learn_button_input(btn_n),
        .role_tx(role_tx), .key_valid(key_valid), .key_code(key_code),
        .rf_activity(rf_activity), .rssi(rssi), .rssi_valid(rssi_valid),
        .pair_wr(pair_wr), .pair_key(pair_key), .pair_ch(pair_ch),
        .store_erase(store_erase), .pair_count(pair_count),
        .ch_out(ch_out), .ch_oe_n(ch_oe_n), .carrier_on(carrier_on),
        .led_onboard(led_onboard),
        .learn_indicator_output(learn_indicator_output),
        .self_test(self_test));

    // Strength samples keep moving so the bar graph logic sees traffic
    always @(posedge clk) begin
        #1 rssi = 8'($urandom);
        rssi_valid = ~rssi_valid;
    end

    // Reference model: each write is matched against the expected queue while it holds entries
    always @(posedge clk) begin
        if (pair_wr === 1'b1) begin
            wr_seen++;
            if (exp_key.size() > 0) begin
                // Pop once: the compare macro evaluates its arguments twice
                ek = exp_key.pop_front();
                ec = exp_ch.pop_front();
                `RPS_CHK("pair_key", ek, pair_key)
                `RPS_CHK("pair_ch", ec, pair_ch)
            end
        end
        if (store_erase === 1'b1) erase_seen++;
        `RPS_CHK("led_mirror", led_onboard, learn_indicator_output)
        if (led_onboard === 1'b1 && led_prev === 1'b0) led_rise++;
        if (led_onboard === 1'b1) led_on_cyc++;
        led_prev = led_onboard;
    end

    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic try_key(input bit ok, input logic [2:0] ch);
        logic [KEY_W-1:0] k;
        int n0;
        k = KEY_W'($urandom);
        n0 = wr_seen;
        if (ok) begin
            exp_key.push_back(k);
            exp_ch.push_back(ch);
            if (model_pairs < MAX_PAIRS) model_pairs++;
        end
        u_hs.send_key(k);
        cyc(4);
        `RPS_CHK("pair_wr_count", n0 + int'(ok), wr_seen)
        `RPS_CHK("pair_count", 6'(model_pairs), pair_count)
    endtask : try_key

    // One press; n is the channel it reaches, so n flashes must fit the wait
    task automatic learn_press(input int n);
        u_hs.press(50 * MS);
        cyc(5600 * n);
    endtask : learn_press

    initial begin
        int r;
        int ok;
        void'($urandom(32'h5aea));
        rst_n = 1'b0;
        role_tx = 1'b0;
        rssi = 8'h00;
        rssi_valid = 1'b0;
        cyc(1);
        `RPS_CHK("reset_outs", {2'h0, 6'h00, 8'h00, 3'h4},
            {pair_wr, store_erase, pair_count, ch_out, ch_oe_n, self_test,
            carrier_on})
        cyc(20);
        rst_n = 1'b1;
        cyc(300);
        // indicator dark without traffic, lit with it
        led_on_cyc = 0;
        cyc(500);
        `RPS_CHK("led_idle", 0, led_on_cyc)
        u_hs.traffic(1'b1);
        cyc(1000);
        u_hs.traffic(1'b0);
        `RPS_CHK("led_traffic", 1, int'(led_on_cyc > 0))
        cyc(300);
        // two presses select channel 2, then bind a key
        led_rise = 0;
        learn_press(1);
        `RPS_CHK("flash_once", 1, led_rise)
        led_rise = 0;
        learn_press(2);
        `RPS_CHK("flash_twice", 2, led_rise)
        try_key(1'b1, 3'h1);
        // fast flashing for the success period, then back to normal
        led_rise = 0;
        cyc(2500 * MS);
        `RPS_CHK("fast_flash", 1, int'(led_rise >= 20))
        cyc(700 * MS);
        try_key(1'b0, 3'h0);
        // learn mode gives up when nothing arrives
        // One count flash, then two slow flashes before the time-out
        led_rise = 0;
        u_hs.press(50 * MS);
        cyc(2400 * MS);
        `RPS_CHK("slow_flash", 3, led_rise)
        try_key(1'b0, 3'h0);
        // transmitter role ignores the learn sequence
        role_tx = 1'b1;
        u_hs.press(50 * MS);
        cyc(600 * MS);
        try_key(1'b0, 3'h0);
        role_tx = 1'b0;
        cyc(100);
        // long hold erases, then flashes while still held
        r = erase_seen;
        u_hs.set_button(1'b1);
        cyc(150 * MS);
        led_rise = 0;
        cyc(150 * MS);
        `RPS_CHK("erase_pulse", r + 1, erase_seen)
        `RPS_CHK("erase_flash", 1, int'(led_rise > 0))
        u_hs.set_button(1'b0);
        model_pairs = 0;
        cyc(50);
        `RPS_CHK("count_cleared", 6'(model_pairs), pair_count)
        // button held through power-up starts the self-test
        u_hs.set_button(1'b1);
        rst_n = 1'b0;
        cyc(20);
        rst_n = 1'b1;
        ok = 0;
        for (int i = 0; i < 1000 && ok == 0; i++) begin
            cyc(1);
            if (self_test === 1'b1) ok = 1;
        end
        `RPS_CHK("self_test", 1, ok)
        u_hs.set_button(1'b0);
        cyc(2);
        `RPS_CHK("outs_driven", 1'b0, ch_oe_n)
        ok = 0;
        for (int i = 0; i < 3000 && ok == 0; i++) begin
            cyc(1);
            if ($countones(ch_out) == 1) ok = 1;
        end
        `RPS_CHK("ramp_first", 1, ok)
        `RPS_CHK("no_carrier", 1'b0, carrier_on)
        complete_run();
    end
endmodule : receiver_pairing_and_self_test_test
